// file: gptbc_pkg.sv
/*
  Package for the timer B mode and control block: register offsets, field
  positions, reset values and mode encodings.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package gptbc_pkg;
  localparam logic [11:0] OFF_WIDTH_CFG = 12'h000;
  localparam logic [11:0] OFF_SECOND_MODE = 12'h008;
  localparam logic [11:0] OFF_CONTROL = 12'h00c;
  localparam logic [11:0] OFF_STATUS = 12'h010;

  localparam int CFG_LSB = 0;
  localparam int CFG_MSB = 2;
  localparam int SMODE_LSB = 0;
  localparam int SMODE_MSB = 1;
  localparam int SCAP_BIT = 2;
  localparam int SEDGE_LSB = 10;
  localparam int SEDGE_MSB = 11;
  localparam int SFREEZE_BIT = 9;
  localparam int SRUN_BIT = 8;
  localparam int CTL_RSVD_BIT = 7;
  localparam int FPWMINV_BIT = 6;
  localparam int FTRIG_BIT = 5;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [2:0] CFG_32BIT = 3'h0;
  localparam logic [2:0] CFG_16BIT_MIN = 3'h4;

  typedef enum logic [1:0] {
    GPTBC_MODE_RSVD = 2'b00,
    GPTBC_MODE_ONESHOT = 2'b01,
    GPTBC_MODE_PERIODIC = 2'b10,
    GPTBC_MODE_CAPTURE = 2'b11
  } gptbc_mode_t;

  typedef enum logic [1:0] {
    GPTBC_EDGE_RISE = 2'b00,
    GPTBC_EDGE_FALL = 2'b01,
    GPTBC_EDGE_RSVD = 2'b10,
    GPTBC_EDGE_BOTH = 2'b11
  } gptbc_edge_t;

  typedef struct packed {
    logic oneShot;
    logic periodic;
    logic capture;
    logic captureTime;
    logic riseDetect;
    logic fallDetect;
    logic countEnable;
  } gptbc_ctrl_t;
endpackage

// file: gptbc_decode.sv
/*
  Decoder of the timer B settings into the control strobes the counter uses.
  Assumes the stored register fields are stable between APB writes.
*/
`timescale 1ns/1ps
module gptbc_decode (
  input wire logic [2:0] widthConfiguration,
  input wire logic [1:0] secondTimerModeField,
  input wire logic secondCaptureType,
  input wire logic [1:0] secondEdgeSelect,
  input wire logic secondRunEnable,
  input wire logic secondDebugFreeze,
  input wire logic debugHalt,
  output gptbc_pkg::gptbc_ctrl_t ctrl
);
  wire logic split16 = widthConfiguration >= gptbc_pkg::CFG_16BIT_MIN;
  // In 32-bit configuration the whole second mode register is ignored
  wire logic modeUsed = split16;
  wire logic frozen = debugHalt & secondDebugFreeze;
  assign ctrl.oneShot = modeUsed &
    (secondTimerModeField == gptbc_pkg::GPTBC_MODE_ONESHOT);
  assign ctrl.periodic = modeUsed &
    (secondTimerModeField == gptbc_pkg::GPTBC_MODE_PERIODIC);
  assign ctrl.capture = modeUsed &
    (secondTimerModeField == gptbc_pkg::GPTBC_MODE_CAPTURE);
  assign ctrl.captureTime = modeUsed & secondCaptureType;
  // Reserved edge code detects nothing rather than guessing
  assign ctrl.riseDetect = (secondEdgeSelect == gptbc_pkg::GPTBC_EDGE_RISE) |
    (secondEdgeSelect == gptbc_pkg::GPTBC_EDGE_BOTH);
  assign ctrl.fallDetect = (secondEdgeSelect == gptbc_pkg::GPTBC_EDGE_FALL) |
    (secondEdgeSelect == gptbc_pkg::GPTBC_EDGE_BOTH);
  assign ctrl.countEnable = secondRunEnable & split16 & ~frozen;
endmodule // gptbc_decode

// file: gptbc_top.sv
/*
  Timer B mode and control registers with APB slave, converter trigger gate
  and PWM polarity for timer A.
  Assumes an APB master on core_clk; timer A PWM and trigger come from the
  counter logic outside and the debug halt level from the processor.
*/
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module gptbc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debugHalt,
  input wire logic firstPwmRaw,
  input wire logic firstTriggerRaw,
  output logic firstPwmOut,
  output logic converterTrigger,
  output gptbc_pkg::gptbc_ctrl_t secondCtrl
);
  logic [2:0] widthCfg_q;
  logic [1:0] secondTimerModeField_q;
  logic secondCaptureType_q;
  logic [1:0] secondEdgeSelect_q;
  logic secondDebugFreeze_q;
  logic secondRunEnable_q;
  logic firstPwmInvert_q;
  logic firstConverterTriggerEnable_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  gptbc_pkg::gptbc_ctrl_t ctrlD;
  gptbc_pkg::gptbc_ctrl_t ctrl_q;
  logic firstPwmOut_q;
  logic converterTrigger_q;

  wire logic access = psel & penable;
  wire logic wrStb = access & pwrite;
  wire logic hitCfg = paddr == gptbc_pkg::OFF_WIDTH_CFG;
  wire logic hitMode = paddr == gptbc_pkg::OFF_SECOND_MODE;
  wire logic hitCtl = paddr == gptbc_pkg::OFF_CONTROL;
  wire logic hitStat = paddr == gptbc_pkg::OFF_STATUS;
  wire logic hitAny = hitCfg | hitMode | hitCtl | hitStat;
  wire logic wrCfg = wrStb & hitCfg;
  wire logic wrMode = wrStb & hitMode;
  wire logic wrCtl = wrStb & hitCtl;

  wire logic [31:0] cfgWord = {29'h0000_0000, widthCfg_q};
  wire logic [31:0] modeWord = {29'h0000_0000, secondCaptureType_q,
    secondTimerModeField_q};
  // Reserved control bit and all unlisted bits read as zero
  wire logic [31:0] ctlWord = {20'h0_0000, secondEdgeSelect_q, secondDebugFreeze_q,
    secondRunEnable_q, 1'b0, firstPwmInvert_q, firstConverterTriggerEnable_q,
    5'h00};
  wire logic [31:0] statWord = {25'h000_0000, ctrl_q};
  wire logic [31:0] rdMux = hitCfg ? cfgWord :
    hitMode ? modeWord :
    hitCtl ? ctlWord :
    hitStat ? statWord : gptbc_pkg::ZERO_WORD;

  gptbc_decode u_decode (
    .widthConfiguration(widthCfg_q),
    .secondTimerModeField(secondTimerModeField_q),
    .secondCaptureType(secondCaptureType_q),
    .secondEdgeSelect(secondEdgeSelect_q),
    .secondRunEnable(secondRunEnable_q),
    .secondDebugFreeze(secondDebugFreeze_q),
    .debugHalt(debugHalt),
    .ctrl(ctrlD)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      widthCfg_q <= gptbc_pkg::CFG_32BIT;
    end else if (wrCfg) begin
      widthCfg_q <= pwdata[gptbc_pkg::CFG_MSB:gptbc_pkg::CFG_LSB];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      secondTimerModeField_q <= gptbc_pkg::GPTBC_MODE_RSVD;
      secondCaptureType_q <= 1'b0;
    end else if (wrMode) begin
      secondTimerModeField_q <= pwdata[gptbc_pkg::SMODE_MSB:gptbc_pkg::SMODE_LSB];
      secondCaptureType_q <= pwdata[gptbc_pkg::SCAP_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      secondEdgeSelect_q <= gptbc_pkg::GPTBC_EDGE_RISE;
      secondDebugFreeze_q <= 1'b0;
      secondRunEnable_q <= 1'b0;
      firstPwmInvert_q <= 1'b0;
      firstConverterTriggerEnable_q <= 1'b0;
    end else if (wrCtl) begin
      secondEdgeSelect_q <= pwdata[gptbc_pkg::SEDGE_MSB:gptbc_pkg::SEDGE_LSB];
      secondDebugFreeze_q <= pwdata[gptbc_pkg::SFREEZE_BIT];
      secondRunEnable_q <= pwdata[gptbc_pkg::SRUN_BIT];
      firstPwmInvert_q <= pwdata[gptbc_pkg::FPWMINV_BIT];
      firstConverterTriggerEnable_q <= pwdata[gptbc_pkg::FTRIG_BIT];
    end
  end

  // Read data registered at the end of the setup cycle; write to read-only status errors
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= gptbc_pkg::RESET_WORD;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= (psel & ~penable & ~pwrite) ? rdMux : prdata_q;
      pslverr_q <= psel & ~penable & (~hitAny | (pwrite & hitStat));
    end
  end

  // Outputs registered so downstream sees one cycle of latency everywhere
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
      firstPwmOut_q <= 1'b0;
      converterTrigger_q <= 1'b0;
    end else begin
      ctrl_q <= ctrlD;
      firstPwmOut_q <= firstPwmRaw ^ firstPwmInvert_q;
      converterTrigger_q <= firstTriggerRaw & firstConverterTriggerEnable_q;
    end
  end

  // Setup cycle captures the answer, access phase completes at once
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = access & pslverr_q;
  assign secondCtrl = ctrl_q;
  assign firstPwmOut = firstPwmOut_q;
  assign converterTrigger = converterTrigger_q;

  p_trig_gate: assert property (@(posedge core_clk) disable iff (rst)
    converterTrigger |-> $past(firstTriggerRaw) && $past(firstConverterTriggerEnable_q))
    else $error("Trigger passed while gated");
  p_pwm_inv: assert property (@(posedge core_clk) disable iff (rst)
    ##1 firstPwmOut == ($past(firstPwmRaw) ^ $past(firstPwmInvert_q)))
    else $error("PWM polarity wrong");
  p_rsvd7: assert property (@(posedge core_clk) disable iff (rst)
    ctlWord[gptbc_pkg::CTL_RSVD_BIT] == 1'b0)
    else $error("Reserved control bit not zero");
  p_mode32: assert property (@(posedge core_clk) disable iff (rst)
    (widthCfg_q == gptbc_pkg::CFG_32BIT) |=> !(secondCtrl.oneShot ||
    secondCtrl.periodic || secondCtrl.capture || secondCtrl.captureTime))
    else $error("Mode used in 32-bit configuration");
  p_mode16: assert property (@(posedge core_clk) disable iff (rst)
    (widthCfg_q >= gptbc_pkg::CFG_16BIT_MIN && secondTimerModeField_q ==
    gptbc_pkg::GPTBC_MODE_CAPTURE) |=> secondCtrl.capture)
    else $error("Capture mode not decoded");
  p_freeze: assert property (@(posedge core_clk) disable iff (rst)
    (debugHalt && secondDebugFreeze_q) |=> !secondCtrl.countEnable)
    else $error("Counter runs while frozen");
  p_nohalt: assert property (@(posedge core_clk) disable iff (rst)
    (!debugHalt && secondRunEnable_q && widthCfg_q >= gptbc_pkg::CFG_16BIT_MIN)
    |=> secondCtrl.countEnable)
    else $error("Freeze acted without halt");
  p_edge: assert property (@(posedge core_clk) disable iff (rst)
    (secondEdgeSelect_q == gptbc_pkg::GPTBC_EDGE_BOTH) |=>
    (secondCtrl.riseDetect && secondCtrl.fallDetect))
    else $error("Both-edge select wrong");
  p_wr_ctl: assert property (@(posedge core_clk) disable iff (rst)
    wrCtl |=> secondRunEnable_q == $past(pwdata[gptbc_pkg::SRUN_BIT]))
    else $error("Run enable not written");
  p_captype: assert property (@(posedge core_clk) disable iff (rst)
    (wrMode && widthCfg_q >= gptbc_pkg::CFG_16BIT_MIN) |=> ##1
    secondCtrl.captureTime == $past(pwdata[gptbc_pkg::SCAP_BIT], 2))
    else $error("Capture type not applied");
endmodule // gptbc_top

// file: gptbc_adc_model.sv
/*
  Converter trigger input model: counts the trigger pulses it receives.
  Assumes a level trigger from the block, sampled on core_clk.
*/
`timescale 1ns/1ps
module gptbc_adc_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic converterTrigger,
  output logic [7:0] trigCount
);
  logic seen_q;
  logic [7:0] count_q;
  assign trigCount = count_q;
  // A held level starts one conversion only, so a stuck trigger shows as one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
      count_q <= 8'h00;
    end else begin
      seen_q <= converterTrigger;
      if (converterTrigger && !seen_q) count_q <= count_q + 8'h01;
    end
  end
endmodule // gptbc_adc_model

// file: gptbc_tb.sv
/*
  Self-checking bench for the timer B mode and control block.
  Assumes the zero-wait APB slave and registered outputs of the design.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [2:0] cfg;
    logic [31:0] mode;
    logic [31:0] ctl;
    logic halt;
    gptbc_pkg::gptbc_ctrl_t exp;
  } gptbc_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic debugHalt = 1'b0;
  logic firstPwmRaw = 1'b0;
  logic firstTriggerRaw = 1'b0;
  logic firstPwmOut;
  logic converterTrigger;
  gptbc_pkg::gptbc_ctrl_t secondCtrl;
  logic [7:0] trigCount;
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  // Expected strobes {oneShot,periodic,capture,captureTime,rise,fall,countEnable}
  gptbc_row_t rows [6] = '{
    '{3'h4, 32'h0000_0001, 32'h0000_0100, 1'b0, 7'h45},
    '{3'h5, 32'h0000_0002, 32'h0000_0400, 1'b0, 7'h22},
    '{3'h7, 32'h0000_0007, 32'h0000_0F00, 1'b1, 7'h1E},
    '{3'h6, 32'h0000_0003, 32'h0000_0300, 1'b0, 7'h15},
    '{3'h4, 32'h0000_0000, 32'h0000_0900, 1'b1, 7'h01},
    '{3'h0, 32'h0000_0007, 32'h0000_0F00, 1'b0, 7'h06}};

  gptbc_top uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debugHalt(debugHalt), .firstPwmRaw(firstPwmRaw),
    .firstTriggerRaw(firstTriggerRaw), .firstPwmOut(firstPwmOut),
    .converterTrigger(converterTrigger), .secondCtrl(secondCtrl));
  gptbc_adc_model adc (.core_clk(core_clk), .rst(rst),
    .converterTrigger(converterTrigger), .trigCount(trigCount));

  always #4 core_clk = ~core_clk;

  // Ceiling well above the roughly 160 cycles the sequence needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chkCtrl(input gptbc_pkg::gptbc_ctrl_t got, input gptbc_pkg::gptbc_ctrl_t exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t strobes %b expected %b", $time, got, exp);
    end
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, gptbc_pkg::OFF_STATUS, 32'h0000_0000);
    chkWord(rd, 32'h0000_0004);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, gptbc_pkg::OFF_WIDTH_CFG, {29'h0000_0000, rows[i].cfg});
      apb(1'b1, gptbc_pkg::OFF_SECOND_MODE, rows[i].mode);
      apb(1'b1, gptbc_pkg::OFF_CONTROL, rows[i].ctl);
      debugHalt <= rows[i].halt;
      repeat (3) @(posedge core_clk);
      chkCtrl(secondCtrl, rows[i].exp);
      apb(1'b0, gptbc_pkg::OFF_STATUS, 32'h0000_0000);
      chkWord(rd, {25'h000_0000, rows[i].exp});
    end
    apb(1'b1, gptbc_pkg::OFF_CONTROL, 32'hFFFF_FFFF);
    apb(1'b0, gptbc_pkg::OFF_CONTROL, 32'h0000_0000);
    chkWord(rd, 32'h0000_0F60);
    apb(1'b1, gptbc_pkg::OFF_SECOND_MODE, 32'hFFFF_FFFF);
    apb(1'b0, gptbc_pkg::OFF_SECOND_MODE, 32'h0000_0000);
    chkWord(rd, 32'h0000_0007);
    // Refused accesses must flag an error and an unmapped read must return zero
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    chkBit(er, 1'b1);
    apb(1'b1, gptbc_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    chkBit(er, 1'b1);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chkWord(rd, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, gptbc_pkg::OFF_CONTROL, {25'h000_0000, i[1], i[0], 5'h00});
      firstPwmRaw <= 1'b1;
      firstTriggerRaw <= 1'b1;
      repeat (3) @(posedge core_clk);
      chkBit(firstPwmOut, ~i[1]);
      chkBit(converterTrigger, i[0]);
      firstTriggerRaw <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    chkWord({24'h00_0000, trigCount}, 32'h0000_0002);
    print_verdict();
  end
endmodule // testbench
